// ===== core/ebpw_host.sv
// Host controller driving a byte-wide EEPROM through its strobe pins
`timescale 1ns/10ps
`include "ebpw_cfg.svh"
module ebpw_host #(
  parameter int PAGE_AW = 7,              // Address bits inside one page
  parameter int WC_CYC  = `EBPW_WC_CYC    // Internal write time in cycles
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  // User request side
  input  wire logic                   req_valid_i,
  input  wire ebpw_pkg::ebpw_req_type req_i,
  output logic                        req_ready_o,
  input  wire logic                   poll_en_i,
  // User answer side
  output logic                        rsp_valid_o,
  output logic [7:0]                  rsp_data_o,
  output logic                        busy_o,
  // Memory pins
  output ebpw_pkg::ebpw_pins_type     mem_o,
  input  wire logic [7:0]             dq_i,
  output logic [7:0]                  dq_o,
  output logic                        dq_oe_n_o
);

  localparam int TW = 18;  // Timer width, fits the internal write time

  // Fixed phase lengths, loaded as length minus one
  localparam logic [TW-1:0] WP_LD  = TW'(`EBPW_WP_CYC - 1);
  localparam logic [TW-1:0] AH_LD  = TW'(`EBPW_AH_CYC - 1);
  localparam logic [TW-1:0] WPH_LD = TW'(`EBPW_WPH_CYC - 1);
  localparam logic [TW-1:0] OES_LD = TW'(`EBPW_OES_CYC - 1);
  localparam logic [TW-1:0] RD_LD  = TW'(`EBPW_RD_ACC_CYC + `EBPW_SYNC_CYC - 1);
  localparam logic [TW-1:0] OHZ_LD = TW'(`EBPW_OHZ_CYC - 1);
  localparam logic [TW-1:0] WIN_LD = TW'(`EBPW_BLC_MAX_CYC - `EBPW_BLC_MARGIN);
  localparam logic [TW-1:0] WIN_OK = TW'(`EBPW_BLC_MAX_CYC - `EBPW_BLC_MARGIN - `EBPW_BLC_MIN_CYC);
  localparam logic [TW-1:0] WC_LD  = TW'(WC_CYC - 1 + `EBPW_BLC_MARGIN);  // Margin covers the window we cut short

  ebpw_pkg::ebpw_state_type state_q;  // Current state
  ebpw_pkg::ebpw_state_type state_d;  // Next state
  ebpw_pkg::ebpw_req_type   cur_q;    // Request being served
  ebpw_pkg::ebpw_req_type   last_q;   // Last byte loaded, target of polls
  ebpw_pkg::ebpw_pins_type  pins_d;   // Next pin levels
  logic                     pend_q;   // Request held while the write settles
  logic                     ready_q;  // Registered ready
  logic                     rsp_valid_q;
  logic [7:0]               rsp_data_q;
  logic                     busy_q;
  logic [7:0]               dq_q;
  logic                     dq_oe_n_q;
  ebpw_pkg::ebpw_pins_type  mem_q;
  logic [7:0]               dq_s1_q;  // First synchroniser stage
  logic [7:0]               dq_s2_q;  // Second stage, the only one read

  // Timer controls
  logic          ph_ld;
  logic [TW-1:0] ph_val;
  logic          ph_zero;
  logic          win_ld;
  logic [TW-1:0] win_cnt;
  logic          win_zero;
  logic          wc_ld;
  logic          wc_zero;

  // Request decode
  wire accept    = req_valid_i && ready_q;
  wire same_page = req_i.addr[15:PAGE_AW] == last_q.addr[15:PAGE_AW];
  wire page_hit  = accept && req_i.write && same_page && !win_zero;
  // Polled bit shows its true value once the write has finished
  wire poll_done = dq_s2_q[`EBPW_POLL_BIT] == last_q.data[`EBPW_POLL_BIT];
  // Where to go once the internal write is over
  wire ebpw_pkg::ebpw_state_type after_wait =
    !pend_q ? ebpw_pkg::ST_IDLE : (cur_q.write ? ebpw_pkg::ST_WSET : ebpw_pkg::ST_RD);

  // Phase timer for strobe widths
  ebpw_tmr #(.W(TW)) u_ph (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (ph_ld),
    .val_i     (ph_val),
    .cnt_o     (),
    .zero_o    (ph_zero)
  );

  // Byte load window timer, restarted at every falling write strobe
  ebpw_tmr #(.W(TW)) u_win (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (win_ld),
    .val_i     (WIN_LD),
    .cnt_o     (win_cnt),
    .zero_o    (win_zero)
  );

  // Internal write timer, started when the page closes
  ebpw_tmr #(.W(TW)) u_wc (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (wc_ld),
    .val_i     (WC_LD),
    .cnt_o     (),
    .zero_o    (wc_zero)
  );

  // Next state and timer loads
  always_comb
  begin
    state_d = state_q;
    ph_ld   = 1'b0;
    ph_val  = '0;
    win_ld  = 1'b0;
    wc_ld   = 1'b0;
    unique case (state_q)
      ebpw_pkg::ST_IDLE:
        if (accept)
        begin
          state_d = req_i.write ? ebpw_pkg::ST_WSET : ebpw_pkg::ST_RD;
          ph_ld   = 1'b1;
          ph_val  = req_i.write ? OES_LD : RD_LD;
        end
      // Strobes set up with output enable high before the write pulse
      ebpw_pkg::ST_WSET:
        if (ph_zero)
        begin
          state_d = ebpw_pkg::ST_WPUL;
          ph_ld   = 1'b1;
          ph_val  = WP_LD;
          win_ld  = 1'b1;
        end
      ebpw_pkg::ST_WPUL:
        if (ph_zero)
        begin
          state_d = ebpw_pkg::ST_WHLD;
          ph_ld   = 1'b1;
          ph_val  = AH_LD;
        end
      ebpw_pkg::ST_WHLD:
        if (ph_zero)
        begin
          state_d = ebpw_pkg::ST_WREC;
          ph_ld   = 1'b1;
          ph_val  = WPH_LD;
        end
      ebpw_pkg::ST_WREC:
        if (ph_zero)
          state_d = ebpw_pkg::ST_PAGE;
      // Page open: other requests are held, the memory writes only after the window lapses
      ebpw_pkg::ST_PAGE:
        if (page_hit)
        begin
          state_d = ebpw_pkg::ST_WSET;
          ph_ld   = 1'b1;
          ph_val  = OES_LD;
        end
        else if (win_zero)
        begin
          state_d = ebpw_pkg::ST_WAIT;
          wc_ld   = 1'b1;
        end
      // Internal write running: poll or sit out the whole time
      ebpw_pkg::ST_WAIT:
        if (poll_en_i)
        begin
          state_d = ebpw_pkg::ST_PRD;
          ph_ld   = 1'b1;
          ph_val  = RD_LD;
        end
        else if (wc_zero)
          state_d = after_wait;
      ebpw_pkg::ST_PRD:
        if (ph_zero)
        begin
          state_d = ebpw_pkg::ST_PGAP;
          ph_ld   = 1'b1;
          ph_val  = OHZ_LD;
        end
      // Strobes high between polls; the sample is judged here
      ebpw_pkg::ST_PGAP:
        if (ph_zero)
        begin
          if (poll_done || wc_zero)
            state_d = after_wait;
          else
          begin
            state_d = ebpw_pkg::ST_PRD;
            ph_ld   = 1'b1;
            ph_val  = RD_LD;
          end
        end
      ebpw_pkg::ST_RD:
        if (ph_zero)
        begin
          state_d = ebpw_pkg::ST_RGAP;
          ph_ld   = 1'b1;
          ph_val  = OHZ_LD;
        end
      ebpw_pkg::ST_RGAP:
        if (ph_zero)
          state_d = ebpw_pkg::ST_IDLE;
    endcase
    // A pending request leaving the wait needs its first phase loaded
    if ((state_q == ebpw_pkg::ST_WAIT || state_q == ebpw_pkg::ST_PGAP) &&
        (state_d == ebpw_pkg::ST_WSET || state_d == ebpw_pkg::ST_RD))
    begin
      ph_ld  = 1'b1;
      ph_val = cur_q.write ? OES_LD : RD_LD;
    end
  end

  // Pin decode: read, write or standby from the next state
  wire st_rd  = state_d == ebpw_pkg::ST_RD || state_d == ebpw_pkg::ST_PRD;
  wire st_wr  = state_d == ebpw_pkg::ST_WSET || state_d == ebpw_pkg::ST_WPUL;
  wire st_drv = st_wr || state_d == ebpw_pkg::ST_WHLD;
  wire poll_a = state_d == ebpw_pkg::ST_PRD;
  assign pins_d.ce_n = !(st_rd || st_wr);
  assign pins_d.oe_n = !st_rd;
  assign pins_d.we_n = state_d != ebpw_pkg::ST_WPUL;
  assign pins_d.addr = poll_a ? last_q.addr : (accept ? req_i.addr : cur_q.addr);

  // Ready when idle, or in the page window past its least spacing with nothing held
  wire ready_d = state_d == ebpw_pkg::ST_IDLE ||
                 (state_d == ebpw_pkg::ST_PAGE && win_cnt <= WIN_OK && !pend_q && !accept);

  // Pin synchroniser: the first stage feeds only the second
  always_ff @(posedge sys_clk_i)
  begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // State, request capture and pending flag
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ebpw_pkg::ST_IDLE;
      cur_q   <= '0;
      last_q  <= '0;
      pend_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (accept)
        cur_q <= req_i;
      // Poll target follows each byte actually loaded
      if (state_q == ebpw_pkg::ST_WSET && ph_zero)
        last_q <= cur_q;
      if (accept && state_q == ebpw_pkg::ST_PAGE && !page_hit)
        pend_q <= 1'b1;
      else if (state_d == ebpw_pkg::ST_WSET || state_d == ebpw_pkg::ST_RD)
        pend_q <= 1'b0;
    end
  end

  // Registered outputs; data is driven only through a write setup, pulse and hold
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      mem_q       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0000};
      dq_q        <= 8'h00;
      dq_oe_n_q   <= 1'b1;
      ready_q     <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      busy_q      <= 1'b0;
    end
    else
    begin
      mem_q       <= pins_d;
      dq_q        <= accept ? req_i.data : cur_q.data;
      dq_oe_n_q   <= !st_drv;
      ready_q     <= ready_d;
      rsp_valid_q <= state_q == ebpw_pkg::ST_RD && ph_zero;
      if (state_q == ebpw_pkg::ST_RD && ph_zero)
        rsp_data_q <= dq_s2_q;
      busy_q      <= state_d != ebpw_pkg::ST_IDLE;
    end
  end

  assign mem_o       = mem_q;
  assign dq_o        = dq_q;
  assign dq_oe_n_o   = dq_oe_n_q;
  assign req_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o  = rsp_data_q;
  assign busy_o      = busy_q;

endmodule // ebpw_host

// ===== shared/ebpw_cfg.svh
// Timing and layout constants for the byte/page write host controller
`ifndef EBPW_CFG_SVH
`define EBPW_CFG_SVH

// System clock rate in MHz
`define EBPW_CLK_MHZ        20
// Least times round up, longest times round down, never below one cycle
`define EBPW_CYC_MIN(ns)    ((((ns) * `EBPW_CLK_MHZ) + 999) / 1000)
`define EBPW_CYC_MAX(ns)    ((((ns) * `EBPW_CLK_MHZ) / 1000) > 0 ? (((ns) * `EBPW_CLK_MHZ) / 1000) : 1)

// Write strobe pulse width and high recovery, in ns
`define EBPW_WP_NS          100
`define EBPW_WPH_NS         100
// Address hold after the strobe rises, in ns
`define EBPW_AH_NS          50
// Output enable high setup before a write, in ns
`define EBPW_OES_NS         10
// Slowest read access and output float time, in ns
`define EBPW_RD_ACC_NS      250
`define EBPW_OHZ_NS         50
// Byte load window, least in ns and longest in us
`define EBPW_BLC_MIN_NS     200
`define EBPW_BLC_MAX_US     100
// Internal write time in ms
`define EBPW_WC_MS          10

// Derived cycle counts
`define EBPW_WP_CYC         `EBPW_CYC_MIN(`EBPW_WP_NS)
`define EBPW_WPH_CYC        `EBPW_CYC_MIN(`EBPW_WPH_NS)
`define EBPW_AH_CYC         `EBPW_CYC_MIN(`EBPW_AH_NS)
`define EBPW_OES_CYC        `EBPW_CYC_MIN(`EBPW_OES_NS)
`define EBPW_RD_ACC_CYC     `EBPW_CYC_MIN(`EBPW_RD_ACC_NS)
`define EBPW_OHZ_CYC        `EBPW_CYC_MIN(`EBPW_OHZ_NS)
`define EBPW_BLC_MIN_CYC    `EBPW_CYC_MIN(`EBPW_BLC_MIN_NS)
`define EBPW_BLC_MAX_CYC    `EBPW_CYC_MAX(`EBPW_BLC_MAX_US * 1000)
`define EBPW_WC_CYC         `EBPW_CYC_MIN(`EBPW_WC_MS * 1000000)
// Cycles spent by the two-flop input synchroniser
`define EBPW_SYNC_CYC       2
// Margin taken off the window so the next strobe falls well inside it
`define EBPW_BLC_MARGIN     3
// Data bit used for completion polling
`define EBPW_POLL_BIT       7

`endif

// ===== shared/ebpw_pkg.sv
// Types shared by the byte/page write host controller
package ebpw_pkg;

  // One user request: read or write of one byte
  typedef struct packed {
    logic        write;  // High for a byte write
    logic [15:0] addr;   // Byte address
    logic [7:0]  data;   // Write data
  } ebpw_req_type;

  // Strobe and address pins towards the memory
  typedef struct packed {
    logic        ce_n;   // Chip select, low active
    logic        oe_n;   // Output enable, low active
    logic        we_n;   // Write strobe, low active
    logic [15:0] addr;   // Address pins
  } ebpw_pins_type;

  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_WSET, ST_WPUL, ST_WHLD, ST_WREC, ST_PAGE,
    ST_WAIT, ST_PRD, ST_PGAP, ST_RD, ST_RGAP
  } ebpw_state_type;

endpackage

// ===== core/ebpw_tmr.sv
// Loadable down counter that stops at zero
`timescale 1ns/10ps
module ebpw_tmr #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  // Load request and value
  input  wire logic         load_i,
  input  wire logic [W-1:0] val_i,
  // Count and zero flag
  output logic      [W-1:0] cnt_o,
  output logic              zero_o
);

  logic [W-1:0] cnt_q;  // Current count

  // Load wins over counting; hold at zero once reached
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= val_i;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign cnt_o  = cnt_q;
  assign zero_o = (cnt_q == '0);

endmodule // ebpw_tmr

// ===== bench/ebpw_mem_model.sv
// Behavioural byte-wide EEPROM answering the host controller's strobes
`timescale 1ns/10ps
module ebpw_mem_model #(
  parameter int WIN_NS = 100000, // Byte load window in ns
  parameter int WR_NS  = 4000    // Internal write time, well inside 10 ms
) (
  // Strobes and address
  input  wire logic [15:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  // Data wire level and our own drive
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  // Count of host timing faults
  output int               fault_o
);
  logic [7:0] arr [int];       // Committed cells
  logic [7:0] pbuf [int];      // Page buffer
  logic [7:0] last_b  = 8'h00; // Last byte loaded, for status
  logic       loading = 1'b0;  // Page open
  logic       wr_busy = 1'b0;  // Internal write running
  realtime    t_fall  = 0.0;   // Start of the last byte load
  // Case compare keeps unknown strobes before reset from faking a load
  wire wr_on = (ce_n_i === 1'b0) && (oe_n_i === 1'b1) && (we_n_i === 1'b0);
  initial fault_o = 0;
  initial dq_o = 8'h5a;
  // Load start: none while busy, loads at least 200 ns apart
  always @(posedge wr_on)
  begin
    if (wr_busy || (loading && $realtime - t_fall < 200.0)) fault_o++;
    t_fall = $realtime;
  end
  // Load end latches the byte; strobe must have been low 100 ns
  always @(negedge wr_on)
  begin
    if ($realtime - t_fall < 100.0) fault_o++;
    pbuf[addr_i] = dq_i;
    last_b = dq_i;
    loading = 1'b1;
  end
  // Page closes once the window lapses, then the self-timed write runs
  initial forever
  begin
    #200;
    if (loading && $realtime - t_fall >= WIN_NS)
    begin
      loading = 1'b0;
      wr_busy = 1'b1;
      #WR_NS;
      foreach (pbuf[k]) arr[k] = pbuf[k];
      pbuf.delete();
      wr_busy = 1'b0;
    end
  end
  // Reads show the inverted status bit while loading or writing
  function automatic logic [7:0] rd_val();
    if (loading || wr_busy) return {~last_b[7], 7'h00};
    return arr.exists(addr_i) ? arr[addr_i] : 8'hff;
  endfunction
  // Drive only in read mode; no pull on the wire, so show a changed value
  always @(ce_n_i, oe_n_i, addr_i, loading, wr_busy)
  begin
    if (!ce_n_i && !oe_n_i) dq_o <= #100 rd_val();
    else dq_o <= #1 ~dq_o;
  end
endmodule // ebpw_mem_model

// ===== bench/ebpw_host_props.sv
// Checker for the host controller's memory pin timing
`timescale 1ns/10ps
module ebpw_host_props #(
  parameter int WC_CYC = 200 // Internal write time in cycles
) (
  // Clock and reset
  input wire logic                    sys_clk_i,
  input wire logic                    resetn_i,
  // Watched ports
  input wire logic                    req_valid_i,
  input wire logic                    req_ready_o,
  input wire logic                    poll_en_i,
  input wire logic                    rsp_valid_o,
  input wire ebpw_pkg::ebpw_pins_type mem_o,
  input wire logic                    dq_oe_n_o
);
  logic [23:0] idle_q; // Cycles since write strobe was last low
  logic [23:0] idle_d;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Saturating, starts full so the first access is never flagged
  assign idle_d = !mem_o.we_n ? 24'h000000 : ((idle_q == 24'hffffff) ? idle_q : idle_q + 24'h000001);
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i) idle_q <= 24'hffffff;
    else idle_q <= idle_d;
  end
  chk_no_data_fight: assert property (!mem_o.oe_n |-> dq_oe_n_o)
    else $error("host drives data during a read");
  chk_we_width: assert property ($fell(mem_o.we_n) |-> ##1 !mem_o.we_n ##1 mem_o.we_n)
    else $error("write strobe not two cycles low");
  chk_we_mode: assert property (!mem_o.we_n |-> !mem_o.ce_n && mem_o.oe_n && !dq_oe_n_o)
    else $error("write strobe outside a write setup");
  chk_addr_hold: assert property ($rose(mem_o.we_n) |-> $stable(mem_o.addr))
    else $error("address moved at write strobe rise");
  chk_load_gap: assert property ($fell(mem_o.we_n) |-> idle_q >= 24'h000002)
    else $error("byte loads closer than four cycles");
  chk_read_len: assert property ($fell(mem_o.oe_n) |-> (!mem_o.oe_n && !mem_o.ce_n) [*7] ##1 mem_o.oe_n)
    else $error("read cycle not seven cycles long");
  chk_rsp_place: assert property (rsp_valid_o |-> !$past(mem_o.oe_n) && mem_o.oe_n)
    else $error("read answer not at read end");
  chk_wait_full: assert property ($fell(mem_o.ce_n) && !mem_o.oe_n && !poll_en_i |-> idle_q >= WC_CYC)
    else $error("read before full write time");
  chk_take_drop: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready stayed high after a take");
  cov_page_load: cover property ($fell(mem_o.we_n) && idle_q < 24'h0007d0);
  cov_poll_read: cover property ($fell(mem_o.oe_n) && poll_en_i);
  cov_rsp: cover property (rsp_valid_o);
endmodule // ebpw_host_props

// ===== bench/tb_ebpw_host.sv
// Testbench for the host controller against a behavioural EEPROM
`timescale 1ns/10ps
module tb_ebpw_host;
  localparam int WC = 200; // Shortened internal write time in cycles
  logic                    sys_clk_i   = 1'b0;
  logic                    resetn_i    = 1'b0;
  logic                    req_valid_i = 1'b0;
  ebpw_pkg::ebpw_req_type  req_i       = '0;
  logic                    poll_en_i   = 1'b0;
  logic                    req_ready_o, rsp_valid_o, busy_o, dq_oe_n_o;
  logic [7:0]              rsp_data_o, dq_o, mem_dq, dq_bus;
  ebpw_pkg::ebpw_pins_type mem_o;
  int                      fault, lat_np;
  int                      n_mismatch = 0;
  int                      compares   = 0;
  // Wire level: host drive wins when enabled, else the memory side
  assign dq_bus = dq_oe_n_o ? mem_dq : dq_o;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  ebpw_host #(.WC_CYC(WC)) u_ebpw_host (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .poll_en_i(poll_en_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .busy_o(busy_o), .mem_o(mem_o), .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
  ebpw_mem_model u_ebpw_mem_model (.addr_i(mem_o.addr), .ce_n_i(mem_o.ce_n), .oe_n_i(mem_o.oe_n),
    .we_n_i(mem_o.we_n), .dq_i(dq_bus), .dq_o(mem_dq), .fault_o(fault));
  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // One request held until taken; reads count cycles from the falling edge after the take
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                      output int lat);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_i = {w, a, d};
    while (req_ready_o !== 1'b1 && n < 9000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    lat = 1;
    while (!w && rsp_valid_o !== 1'b1 && lat < 9000)
    begin
      @(negedge sys_clk_i);
      lat++;
    end
    q = rsp_data_o;
    if (n >= 9000 || lat >= 9000) chk(8'h00, 8'h01, "handshake timeout");
    if (n >= 9000 || lat >= 9000) conclude();
  endtask
  task automatic t_single();
    logic [7:0] q;
    int         lat;
    xfer(1'b1, 16'h0123, 8'h3c, q, lat);
    chk({7'h00, busy_o}, 8'h01, "busy not raised by write");
    xfer(1'b0, 16'h0123, 8'h00, q, lat_np);
    chk(q, 8'h3c, "single byte read back");
    $display("test single done");
  endtask
  // Four loads ending on the last byte of a page
  task automatic t_page();
    logic [7:0] q;
    int         lat;
    for (int i = 0; i < 4; i++) xfer(1'b1, 16'h02fc + 16'(i), 8'ha0 + 8'(i), q, lat);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 16'h02fc + 16'(i), 8'h00, q, lat);
      chk(q, 8'ha0 + 8'(i), "page byte read back");
    end
    $display("test page done");
  endtask
  // Polling must end the wait sooner than the full write time
  task automatic t_poll();
    logic [7:0] q;
    int         lat;
    poll_en_i = 1'b1;
    xfer(1'b1, 16'h0305, 8'h80, q, lat);
    xfer(1'b0, 16'h0305, 8'h00, q, lat);
    chk(q, 8'h80, "polled byte read back");
    chk({7'h00, lat < lat_np}, 8'h01, "polling did not end wait early");
    poll_en_i = 1'b0;
    $display("test poll done");
  endtask
  task automatic t_idle();
    logic [7:0] q;
    int         lat;
    xfer(1'b0, 16'h7777, 8'h00, q, lat);
    chk(q, 8'hff, "erased cell read");
    // Five access, two sync and one answer register cycle, counted from the falling edge after the take
    chk(8'(lat), 8'h08, "read answer latency");
    @(negedge sys_clk_i);
    chk({7'h00, busy_o}, 8'h00, "busy stuck after read");
    $display("test idle read done");
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    t_single();
    t_page();
    t_poll();
    t_idle();
    chk(8'(fault), 8'h00, "memory saw a timing fault");
    conclude();
  end
endmodule // tb_ebpw_host
bind ebpw_host ebpw_host_props #(.WC_CYC(WC_CYC)) u_ebpw_host_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .poll_en_i(poll_en_i), .rsp_valid_o(rsp_valid_o),
  .mem_o(mem_o), .dq_oe_n_o(dq_oe_n_o));
